// File: verilog/ist_consts.svh
`ifndef IST_CONSTS_SVH
`define IST_CONSTS_SVH

// Register offsets (byte addresses on the register bus)
`define IST_OFS_CTRL 8'h00
`define IST_OFS_WREG 8'h04
`define IST_OFS_STAT 8'h08
`define IST_OFS_PC 8'h0C
`define IST_OFS_WDOG 8'h10
`define IST_OFS_INDEX 8'h14

// Field positions
`define IST_CTRL_XEN_BIT 0
`define IST_CTRL_BANK_LSB 8
`define IST_STAT_N_BIT 0
`define IST_STAT_Z_BIT 1
`define IST_STAT_TO_BIT 2
`define IST_STAT_PD_BIT 3

// Reset values
`define IST_XEN_RST 1'b0
`define IST_BANK_RST 4'h0
`define IST_WREG_RST 8'h00
`define IST_PC_RST 16'h0000
`define IST_INDEX_RST 12'h000
`define IST_FLAG_SET 1'b1
`define IST_WDOG_CLEAR 8'h00
`define IST_POST_CLEAR 8'h00

// Opcode patterns
`define IST_BITCLR_PAT 4'h9
`define IST_BRANCH_PAT 8'hE6
`define IST_KICK_WORD 16'h0004
`define IST_INVERT_PAT 6'h07

// Addressing and sequencing
`define IST_ILO_LIMIT 8'h5F
`define IST_ACCESS_HI_PAGE 4'hF
`define IST_PC_STEP 16'h0002

`endif

// File: verilog/ist_pkg.sv
package ist_pkg;

   typedef enum logic [1:0] {
      IST_Q1 = 2'b00,
      IST_Q2 = 2'b01,
      IST_Q3 = 2'b10,
      IST_Q4 = 2'b11
   } ist_phase_t;

   typedef enum logic [2:0] {
      IST_OP_NONE = 3'b000,
      IST_OP_BITCLR = 3'b001,
      IST_OP_BRANCH = 3'b010,
      IST_OP_KICK = 3'b011,
      IST_OP_INVERT = 3'b100
   } ist_op_t;

   typedef struct packed {
      ist_op_t op;
      logic [2:0] bit_idx;
      logic bank_sel;
      logic dest_file;
      logic [7:0] file_addr;
   } ist_instr_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic we;
   } ist_dm_req_t;

endpackage

// File: verilog/ist_exec.sv
// Notes on behaviour
// RQ1: Bit clear (1001 b a f) forces bit b of the file register to zero.
// RQ2: Bank flag 0 uses access bank; flag 1 takes upper address from bank_pointer.
// RQ3: Flag 0, extended set on, address up to 5Fh: indexed literal offset address.
// RQ4: Taken branch_if_minus loads PC+2+2n and costs two instruction cycles.
// RQ5: watchdog_kick_op clears counter and postscaler, sets timeout and sleep flags.
// RQ6: invert_file_op complements the operand, updates only N and Z, one cycle.
// RQ7: Invert destination flag 0 writes W; flag 1 writes back to the file register.
// RQ8: extended_set_enable resets to 0, which disables indexed literal offset addressing.
// RQ9: Four phases decode, read, process, write; bit clear and branch keep flags.
// RQ10: Untaken branch advances PC by 2 in one cycle, no PC write in last phase.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "ist_consts.svh"
module ist_exec (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [15:0] i_instr_word,
   input wire logic i_instr_valid,
   output logic o_instr_ready,
   output logic [15:0] o_pc,
   output ist_pkg::ist_dm_req_t o_dm,
   input wire logic [7:0] i_dm_rdata
);

   function automatic ist_pkg::ist_instr_t decode(input logic [15:0] w);
      ist_pkg::ist_instr_t r;
      r = '{op: ist_pkg::IST_OP_NONE, bit_idx: w[11:9], bank_sel: w[8], dest_file: w[9], file_addr: w[7:0]};
      if (w[15:12] == `IST_BITCLR_PAT) begin
         r.op = ist_pkg::IST_OP_BITCLR;
      end else if (w[15:8] == `IST_BRANCH_PAT) begin
         r.op = ist_pkg::IST_OP_BRANCH;
      end else if (w == `IST_KICK_WORD) begin
         r.op = ist_pkg::IST_OP_KICK;
      end else if (w[15:10] == `IST_INVERT_PAT) begin
         r.op = ist_pkg::IST_OP_INVERT;
      end
      return r;
   endfunction

   function automatic logic [11:0] operand_addr(input ist_pkg::ist_instr_t i, input logic xen,
                                                input logic [3:0] bank, input logic [11:0] base);
      logic [11:0] a;
      if (i.bank_sel) begin
         a = {bank, i.file_addr}; // RQ2
      end else if (xen && i.file_addr <= `IST_ILO_LIMIT) begin
         a = base + {4'h0, i.file_addr}; // RQ3
      end else if (i.file_addr <= `IST_ILO_LIMIT) begin
         a = {4'h0, i.file_addr}; // RQ2
      end else begin
         a = {`IST_ACCESS_HI_PAGE, i.file_addr};
      end
      return a;
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int k = 0; k < 4; k++) begin
         if (be[k]) begin
            r[k*8 +: 8] = nw[k*8 +: 8];
         end
      end
      return r;
   endfunction

   // Bus slave: one wait cycle, read data registered, write commits on the acknowledging edge
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic bus_wr;

   // Core state
   ist_pkg::ist_phase_t phase_q, phase_d;
   ist_pkg::ist_instr_t instr_q, instr_d;
   ist_pkg::ist_dm_req_t dm_q, dm_d;
   logic flush_q, flush_d;
   logic [15:0] pc_q, pc_d;
   logic [7:0] w_q, w_d;
   logic [7:0] opnd_q, opnd_d;
   logic [7:0] result_q, result_d;
   logic n_q, n_d;
   logic z_q, z_d;
   logic xen_q, xen_d;
   logic [3:0] bank_q, bank_d;
   logic [11:0] index_q, index_d;
   logic kick;

   // Watchdog state
   logic [7:0] post_q, post_d;
   logic [7:0] wdog_q, wdog_d;
   logic to_q, to_d;
   logic pd_q, pd_d;

   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
   assign bus_wr = i_avs_write & ack_q;
   assign o_avs_readdata = rdata_q;

   always_comb begin
      ack_d = (i_avs_read | i_avs_write) & ~ack_q;
      rdata_d = rdata_q;
      if (i_avs_read && !ack_q) begin
         case (i_avs_address)
            `IST_OFS_CTRL: rdata_d = {20'h00000, bank_q, 7'h00, xen_q};
            `IST_OFS_WREG: rdata_d = {24'h000000, w_q};
            `IST_OFS_STAT: rdata_d = {28'h0000000, pd_q, to_q, z_q, n_q};
            `IST_OFS_PC: rdata_d = {16'h0000, pc_q};
            `IST_OFS_WDOG: rdata_d = {16'h0000, post_q, wdog_q};
            `IST_OFS_INDEX: rdata_d = {20'h00000, index_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_instr_ready = (phase_q == ist_pkg::IST_Q1) & ~flush_q;
   assign o_pc = pc_q;
   assign o_dm = dm_q;
   assign kick = (phase_q == ist_pkg::IST_Q3) && (instr_q.op == ist_pkg::IST_OP_KICK);

   always_comb begin
      logic [31:0] m;
      ist_pkg::ist_instr_t dec;
      m = 32'h00000000;
      dec = decode(i_instr_word);
      phase_d = phase_q;
      instr_d = instr_q;
      dm_d = dm_q;
      flush_d = flush_q;
      pc_d = pc_q;
      w_d = w_q;
      opnd_d = opnd_q;
      result_d = result_q;
      n_d = n_q;
      z_d = z_q;
      xen_d = xen_q;
      bank_d = bank_q;
      index_d = index_q;
      // Software writes land first; an instruction finishing in the same cycle overrides them
      if (bus_wr) begin
         case (i_avs_address)
            `IST_OFS_CTRL: begin
               m = be_merge({20'h00000, bank_q, 7'h00, xen_q}, i_avs_writedata, i_avs_byteenable);
               xen_d = m[`IST_CTRL_XEN_BIT];
               bank_d = m[`IST_CTRL_BANK_LSB +: 4];
            end
            `IST_OFS_WREG: begin
               m = be_merge({24'h000000, w_q}, i_avs_writedata, i_avs_byteenable);
               w_d = m[7:0];
            end
            `IST_OFS_STAT: begin
               m = be_merge({30'h00000000, z_q, n_q}, i_avs_writedata, i_avs_byteenable);
               n_d = m[`IST_STAT_N_BIT];
               z_d = m[`IST_STAT_Z_BIT];
            end
            `IST_OFS_PC: begin
               m = be_merge({16'h0000, pc_q}, i_avs_writedata, i_avs_byteenable);
               pc_d = m[15:0];
            end
            `IST_OFS_INDEX: begin
               m = be_merge({20'h00000, index_q}, i_avs_writedata, i_avs_byteenable);
               index_d = m[11:0];
            end
            default: m = 32'h00000000;
         endcase
      end
      case (phase_q) // RQ9
         ist_pkg::IST_Q1: begin
            dm_d.we = 1'b0;
            if (flush_q) begin
               // Second cycle of a taken branch: ready stays low, no word is accepted and an empty cycle runs
               flush_d = 1'b0;
               instr_d.op = ist_pkg::IST_OP_NONE;
               phase_d = ist_pkg::IST_Q2;
            end else if (i_instr_valid) begin
               instr_d = dec;
               dm_d.addr = operand_addr(dec, xen_q, bank_q, index_q); // RQ2 RQ3 RQ8
               pc_d = pc_q + `IST_PC_STEP; // RQ10
               phase_d = ist_pkg::IST_Q2;
            end
         end
         ist_pkg::IST_Q2: begin
            opnd_d = i_dm_rdata;
            phase_d = ist_pkg::IST_Q3;
         end
         ist_pkg::IST_Q3: begin
            phase_d = ist_pkg::IST_Q4;
            case (instr_q.op)
               ist_pkg::IST_OP_BITCLR: begin
                  result_d = opnd_q & ~(8'h01 << instr_q.bit_idx); // RQ1
                  dm_d.wdata = result_d;
                  dm_d.we = 1'b1;
               end
               ist_pkg::IST_OP_INVERT: begin
                  result_d = ~opnd_q; // RQ6
                  dm_d.wdata = result_d;
                  dm_d.we = instr_q.dest_file; // RQ7
               end
               default: result_d = result_q;
            endcase
         end
         ist_pkg::IST_Q4: begin
            dm_d.we = 1'b0;
            phase_d = ist_pkg::IST_Q1;
            if (instr_q.op == ist_pkg::IST_OP_INVERT) begin
               n_d = result_q[7]; // RQ6
               z_d = (result_q == 8'h00);
               if (!instr_q.dest_file) begin
                  w_d = result_q; // RQ7
               end
            end else if (instr_q.op == ist_pkg::IST_OP_BRANCH && n_q) begin
               pc_d = pc_q + {{7{instr_q.file_addr[7]}}, instr_q.file_addr, 1'b0}; // RQ4
               flush_d = 1'b1;
            end
         end
         default: phase_d = ist_pkg::IST_Q1;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase_q <= ist_pkg::IST_Q1;
         instr_q <= '{op: ist_pkg::IST_OP_NONE, bit_idx: 3'h0, bank_sel: 1'b0, dest_file: 1'b1, file_addr: 8'h00};
         dm_q <= '{addr: 12'h000, wdata: 8'h00, we: 1'b0};
         flush_q <= 1'b0;
         pc_q <= `IST_PC_RST;
         w_q <= `IST_WREG_RST;
         opnd_q <= 8'h00;
         result_q <= 8'h00;
         n_q <= 1'b0;
         z_q <= 1'b0;
         xen_q <= `IST_XEN_RST; // RQ8
         bank_q <= `IST_BANK_RST;
         index_q <= `IST_INDEX_RST;
      end else begin
         phase_q <= phase_d;
         instr_q <= instr_d;
         dm_q <= dm_d;
         flush_q <= flush_d;
         pc_q <= pc_d;
         w_q <= w_d;
         opnd_q <= opnd_d;
         result_q <= result_d;
         n_q <= n_d;
         z_q <= z_d;
         xen_q <= xen_d;
         bank_q <= bank_d;
         index_q <= index_d;
      end
   end

   // Watchdog: postscaler counts every clock, counter steps on postscaler wrap
   always_comb begin
      post_d = post_q + 8'h01;
      wdog_d = (post_q == 8'hFF) ? wdog_q + 8'h01 : wdog_q;
      to_d = (post_q == 8'hFF && wdog_q == 8'hFF) ? 1'b0 : to_q;
      pd_d = pd_q;
      if (kick) begin
         post_d = `IST_POST_CLEAR; // RQ5
         wdog_d = `IST_WDOG_CLEAR;
         to_d = `IST_FLAG_SET;
         pd_d = `IST_FLAG_SET;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         post_q <= `IST_POST_CLEAR;
         wdog_q <= `IST_WDOG_CLEAR;
         to_q <= `IST_FLAG_SET;
         pd_q <= `IST_FLAG_SET;
      end else begin
         post_q <= post_d;
         wdog_q <= wdog_d;
         to_q <= to_d;
         pd_q <= pd_d;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);

   bitclr_write_a: assert property ( // RQ1
      (phase_q == ist_pkg::IST_Q4 && instr_q.op == ist_pkg::IST_OP_BITCLR)
      |-> dm_q.we && dm_q.wdata[instr_q.bit_idx] == 1'b0 && (dm_q.wdata | (8'h01 << instr_q.bit_idx))
          == (opnd_q | (8'h01 << instr_q.bit_idx)))
      else $error("bit clear result wrong");

   bank_address_a: assert property ( // RQ2
      (phase_q == ist_pkg::IST_Q2 && instr_q.bank_sel && instr_q.op != ist_pkg::IST_OP_NONE)
      |-> dm_q.addr == {$past(bank_q), instr_q.file_addr})
      else $error("banked operand address wrong");

   indexed_address_a: assert property ( // RQ3
      (phase_q == ist_pkg::IST_Q2 && !instr_q.bank_sel && $past(xen_q) && instr_q.file_addr <= `IST_ILO_LIMIT
       && instr_q.op != ist_pkg::IST_OP_NONE)
      |-> dm_q.addr == $past(index_q) + {4'h0, instr_q.file_addr})
      else $error("indexed operand address wrong");

   branch_taken_a: assert property ( // RQ4
      (phase_q == ist_pkg::IST_Q4 && instr_q.op == ist_pkg::IST_OP_BRANCH && n_q && !bus_wr)
      |=> pc_q == $past(pc_q) + {{7{$past(instr_q.file_addr[7])}}, $past(instr_q.file_addr), 1'b0}
          && flush_q && !o_instr_ready ##1 !o_instr_ready [*3] ##1 o_instr_ready)
      else $error("taken branch target or timing wrong");

   kick_clear_a: assert property ( // RQ5
      kick |=> wdog_q == `IST_WDOG_CLEAR && post_q == `IST_POST_CLEAR && to_q && pd_q)
      else $error("watchdog kick did not clear");

   invert_flags_a: assert property ( // RQ6
      (phase_q == ist_pkg::IST_Q3 && instr_q.op == ist_pkg::IST_OP_INVERT && !bus_wr)
      ##1 !bus_wr |=> n_q == ~$past(opnd_q, 2) >> 7 && z_q == ($past(opnd_q, 2) == 8'hFF))
      else $error("invert flags wrong");

   invert_dest_a: assert property ( // RQ7
      (phase_q == ist_pkg::IST_Q3 && instr_q.op == ist_pkg::IST_OP_INVERT)
      |=> dm_q.we == $past(instr_q.dest_file) && dm_q.wdata == ~$past(opnd_q))
      else $error("invert destination wrong");

   plain_access_a: assert property ( // RQ8
      (phase_q == ist_pkg::IST_Q2 && !$past(xen_q) && !instr_q.bank_sel && instr_q.op != ist_pkg::IST_OP_NONE)
      |-> dm_q.addr[11:8] == ((instr_q.file_addr <= `IST_ILO_LIMIT) ? 4'h0 : `IST_ACCESS_HI_PAGE))
      else $error("extended addressing used while disabled");

   flags_kept_a: assert property ( // RQ9
      (phase_q == ist_pkg::IST_Q4 && instr_q.op != ist_pkg::IST_OP_INVERT && !bus_wr)
      |=> $stable(n_q) && $stable(z_q))
      else $error("flags changed by non-invert op");

   not_taken_a: assert property ( // RQ10
      (phase_q == ist_pkg::IST_Q4 && instr_q.op == ist_pkg::IST_OP_BRANCH && !n_q && !bus_wr)
      |=> $stable(pc_q) && !flush_q && o_instr_ready)
      else $error("untaken branch changed PC or stalled");

endmodule // ist_exec

// File: tb/ist_exec_tb.sv
`timescale 1ns/100ps
module tb;
   logic i_clk_sys;
   logic i_reset_n;
   logic [7:0] av_addr;
   logic av_rd;
   logic av_wr;
   logic [31:0] av_wdata;
   logic [31:0] av_rdata;
   logic av_wait;
   logic ready;
   logic ivalid;
   logic [15:0] iword;
   logic [15:0] pc;
   ist_pkg::ist_dm_req_t dm;
   logic [7:0] mem [0:4095];
   logic [31:0] x;
   logic [11:0] a;
   int bad_count;
   int cmp_count;
   int we_n;
   int st;
   // Addressing table: control word, instruction, expected operand address
   localparam logic [31:0] tctl [0:5] = '{32'h300, 32'h300, 32'h301, 32'h301, 32'h301, 32'h300};
   localparam logic [15:0] tins [0:5] = '{16'h9F45, 16'h9080, 16'h925F, 16'h9460, 16'h9710, 16'h9810};
   localparam logic [11:0] tadr [0:5] = '{12'h345, 12'hF80, 12'h25F, 12'hF60, 12'h310, 12'h010};

   ist_exec uut (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_avs_address(av_addr),
      .i_avs_read(av_rd),
      .i_avs_write(av_wr),
      .i_avs_writedata(av_wdata),
      .i_avs_byteenable(4'hF),
      .o_avs_readdata(av_rdata),
      .o_avs_waitrequest(av_wait),
      .i_instr_word(iword),
      .i_instr_valid(ivalid),
      .o_instr_ready(ready),
      .o_pc(pc),
      .o_dm(dm),
      .i_dm_rdata(mem[dm.addr])
   );

   // Data memory stand-in: read is combinational from the address, as the core expects
   always @(posedge i_clk_sys) begin
      if (dm.we === 1'b1) begin
         mem[dm.addr] <= dm.wdata;
         we_n <= we_n + 1;
      end
   end

   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end

   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
      logic w;
      av_rd <= !wr;
      av_wr <= wr;
      av_addr <= ad;
      av_wdata <= wd;
      do begin
         @(posedge i_clk_sys);
         w = av_wait;
      end while (w !== 1'b0);
      rd = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      @(posedge i_clk_sys);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      logic [31:0] y;
      bus(1'b1, ad, d, y);
   endtask

   task automatic rdc(input logic [7:0] ad, input logic [31:0] exp, input string what);
      logic [31:0] y;
      bus(1'b0, ad, 32'h0, y);
      chk(y, exp, what);
   endtask

   // Offers one word, counts the cycles until ready is seen high (the accepting one included), returns the operand address shown in Q2
   task automatic exec(input logic [15:0] w, output int stalls, output logic [11:0] oa);
      logic r;
      stalls = 0;
      ivalid <= 1'b1;
      iword <= w;
      do begin
         @(negedge i_clk_sys);
         r = ready;
         stalls++;
         @(posedge i_clk_sys);
      end while (r !== 1'b1);
      ivalid <= 1'b0;
      @(negedge i_clk_sys);
      oa = dm.addr;
      @(posedge i_clk_sys);
   endtask

   // Three edges: the Q4 memory write and a taken branch's PC settle at the second, the third is spare
   task automatic done();
      repeat (3) @(posedge i_clk_sys);
   endtask

   initial begin
      repeat (20000) @(posedge i_clk_sys);
      bad_count++;
      complete_run();
   end

   initial begin
      i_reset_n = 1'b0;
      av_addr = 8'h00;
      av_rd = 1'b0;
      av_wr = 1'b0;
      av_wdata = 32'h0;
      ivalid = 1'b0;
      iword = 16'h0000;
      bad_count = 0;
      cmp_count = 0;
      we_n = 0;
      for (int i = 0; i < 4096; i++) mem[i] = 8'hFF;
      repeat (2) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      @(posedge i_clk_sys);
      rdc(8'h00, 32'h0, "ctrl reset");
      rdc(8'h08, 32'h0000000C, "stat reset");
      rdc(8'h40, 32'h0, "unmapped read");
      wr(8'h08, 32'h0);
      rdc(8'h08, 32'h0000000C, "stat read-only bits");
      for (int b = 0; b < 8; b++) begin
         exec({4'h9, b[2:0], 1'b0, 8'h20}, st, a);
         done();
         chk({20'h0, a}, 32'h020, "access address");
         chk({24'h0, mem[12'h020]}, {24'h0, 8'hFF & ~(8'h01 << b)}, "bit clear");
         mem[12'h020] <= 8'hFF;
      end
      rdc(8'h08, 32'h0000000C, "flags after bit clear");
      wr(8'h14, 32'h200);
      for (int i = 0; i < 6; i++) begin
         wr(8'h00, tctl[i]);
         exec(tins[i], st, a);
         done();
         chk({20'h0, a}, {20'h0, tadr[i]}, "operand address");
         chk({24'h0, mem[tadr[i]]}, {24'h0, 8'hFF & ~(8'h01 << tins[i][11:9])}, "bit clear mapped");
      end
      wr(8'h00, 32'h300);
      mem[12'h030] <= 8'h13;
      exec(16'h1E30, st, a);
      done();
      chk({24'h0, mem[12'h030]}, 32'hEC, "invert to file");
      rdc(8'h08, 32'h0000000D, "flags negative");
      wr(8'h04, 32'h55);
      exec(16'h1C31, st, a);
      done();
      rdc(8'h04, 32'h0, "invert to W");
      chk({24'h0, mem[12'h031]}, 32'hFF, "file kept");
      rdc(8'h08, 32'h0000000E, "flags zero");
      exec(16'h9020, st, a);
      done();
      rdc(8'h08, 32'h0000000E, "flags kept");
      // Let the watchdog counter step at least once before the kick
      repeat (300) @(posedge i_clk_sys);
      bus(1'b0, 8'h10, 32'h0, x);
      chk({31'h0, |x[7:0]}, 32'h1, "counter running");
      wr(8'h0C, 32'h0100);
      exec(16'hE605, st, a);
      exec(16'h0004, st, a);
      chk(st, 3, "untaken branch timing");
      done();
      chk({16'h0, pc}, 32'h0104, "untaken pc");
      bus(1'b0, 8'h10, 32'h0, x);
      chk({x[31:12], x[7:0]}, 28'h0, "watchdog cleared");
      rdc(8'h08, 32'h0000000E, "kick flags");
      mem[12'h032] <= 8'h00;
      exec(16'h1E32, st, a);
      done();
      wr(8'h0C, 32'h0200);
      exec(16'hE605, st, a);
      exec(16'h0004, st, a);
      chk(st, 7, "taken branch timing");
      done();
      chk({16'h0, pc}, 32'h020E, "taken pc forward");
      wr(8'h0C, 32'h0300);
      exec(16'hE680, st, a);
      done();
      chk({16'h0, pc}, 32'h0202, "taken pc backward");
      rdc(8'h08, 32'h0000000D, "flags after branch");
      repeat (4) @(posedge i_clk_sys);
      chk(we_n, 17, "memory write count");
      complete_run();
   end
endmodule // tb
